// [rtl/led_boost_pwm_config_regs.sv]
// Converter voltage setting and external dimming / safety enable registers
`timescale 1ns/1ns
// Function
// - An eight-bit converter setting selects 8 V to 20 V in 1 V steps for codes 0x08 to 0x14.
// - The converter setting resets to 0x08 and all its bits read and write.
// - Bits 7, 6, 5 of the dimming register enable the safety function of red, green, blue.
// - Bits 4, 3, 2 place red, green, blue under the external dimming input.
// - Bits 1 and 0 enable external dimming of the primary and secondary strings.
// - All eight bits of the dimming register read and write and reset to zero.
// - The external dimming pin acts only while its pin enable bit is set.
// - A read-only status shows whether the safety function has been activated.
// - The converter runs only while its enable bit is set.
module led_boost_pwm_config_regs (
  input  wire logic                          CLK_I,              // 250 MHz clock
  input  wire logic                          RESET_N_I,          // Async reset, active low
  input  wire led_cfg_pkg::reg_req_t         REQ_I,              // Register request
  input  wire logic                          PWM_PIN_I,          // External dimming input level
  input  wire logic                          PWM_PIN_ENABLE_I,   // Pin enable bit from pin config
  input  wire logic                          BOOST_ENABLE_I,     // Converter enable bit
  input  wire logic                          SAFETY_TRIPPED_I,   // Safety timer has fired
  output logic [7:0]                         RDATA_O,            // Read data
  output logic                               RVALID_O,           // Read data valid pulse
  output logic [7:0]                         CONV_CODE_O,        // Converter voltage code
  output logic                               CONV_CODE_OK_O,     // Code within 8 V to 20 V
  output logic                               CONV_RUN_O,         // Converter allowed to run
  output led_cfg_pkg::channel_set_t          SAFETY_EN_O,        // Safety enable per output
  output led_cfg_pkg::channel_set_t          EXT_SEL_O,          // External dimming selected
  output led_cfg_pkg::channel_set_t          EXT_GATE_O,         // External dimming gate level
  output logic                               SAFETY_FLAG_O       // Safety activated status
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic                       hit_conv;
  logic                       hit_dim;

  // Writes to any other address fall through and change nothing
  assign hit_conv = (REQ_I.addr == led_cfg_pkg::CONV_SETTING_ADR);
  assign hit_dim  = (REQ_I.addr == led_cfg_pkg::DIM_SAFETY_ADR);

  // ---------------------------------------------------------------
  // Converter setting register
  // ---------------------------------------------------------------
  logic [7:0]                 conv_setting;
  logic [7:0]                 next_conv_setting;

  // Out-of-range codes are kept as written and only flagged downstream
  always_comb begin
    next_conv_setting = conv_setting;
    if (REQ_I.wr && hit_conv) begin
      next_conv_setting = REQ_I.wdata;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      conv_setting <= led_cfg_pkg::CONV_SETTING_RST;
    end else begin
      conv_setting <= next_conv_setting;
    end
  end

  // ---------------------------------------------------------------
  // Dimming and safety enable register
  // ---------------------------------------------------------------
  led_cfg_pkg::dim_safety_t   dim_safety;
  led_cfg_pkg::dim_safety_t   next_dim_safety;

  always_comb begin
    next_dim_safety = dim_safety;
    if (REQ_I.wr && hit_dim) begin
      next_dim_safety = led_cfg_pkg::dim_safety_t'(REQ_I.wdata);
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dim_safety <= led_cfg_pkg::dim_safety_t'(led_cfg_pkg::DIM_SAFETY_RST);
    end else begin
      dim_safety <= next_dim_safety;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] next_rdata;
  logic       next_rvalid;

  // Read returns the value held before a same-cycle write
  always_comb begin
    next_rvalid = REQ_I.rd;
    next_rdata  = RDATA_O;
    if (REQ_I.rd) begin
      if (hit_conv) begin
        next_rdata = conv_setting;
      end else if (hit_dim) begin
        next_rdata = dim_safety;
      end else begin
        next_rdata = led_cfg_pkg::UNMAPPED_RDATA;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RDATA_O  <= 8'h00;
      RVALID_O <= 1'b0;
    end else begin
      RDATA_O  <= next_rdata;
      RVALID_O <= next_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // Converter controls
  // ---------------------------------------------------------------
  logic next_code_ok;
  logic next_run;

  always_comb begin
    next_code_ok = (next_conv_setting >= led_cfg_pkg::CONV_CODE_MIN) &&
                   (next_conv_setting <= led_cfg_pkg::CONV_CODE_MAX);
    next_run     = BOOST_ENABLE_I;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CONV_CODE_O    <= led_cfg_pkg::CONV_SETTING_RST;
      CONV_CODE_OK_O <= 1'b1;
      CONV_RUN_O     <= 1'b0;
    end else begin
      CONV_CODE_O    <= next_conv_setting;
      CONV_CODE_OK_O <= next_code_ok;
      CONV_RUN_O     <= next_run;
    end
  end

  // ---------------------------------------------------------------
  // Safety enables
  // ---------------------------------------------------------------
  led_cfg_pkg::channel_set_t next_safety_en;

  // Backlight strings carry no safety timer, so their lanes stay off
  always_comb begin
    next_safety_en.red_output       = next_dim_safety.red_safety_on;
    next_safety_en.green_output     = next_dim_safety.green_safety_on;
    next_safety_en.blue_output      = next_dim_safety.blue_safety_on;
    next_safety_en.primary_string   = 1'b0;
    next_safety_en.secondary_string = 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SAFETY_EN_O <= '0;
    end else begin
      SAFETY_EN_O <= next_safety_en;
    end
  end

  // ---------------------------------------------------------------
  // External dimming selects
  // ---------------------------------------------------------------
  led_cfg_pkg::channel_set_t next_ext_sel;

  always_comb begin
    next_ext_sel.red_output       = next_dim_safety.red_pin_dimming_on;
    next_ext_sel.green_output     = next_dim_safety.green_pin_dimming_on;
    next_ext_sel.blue_output      = next_dim_safety.blue_pin_dimming_on;
    next_ext_sel.primary_string   = next_dim_safety.primary_string_pin_dimming_on;
    next_ext_sel.secondary_string = next_dim_safety.secondary_string_pin_dimming_on;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      EXT_SEL_O <= '0;
    end else begin
      EXT_SEL_O <= next_ext_sel;
    end
  end

  // ---------------------------------------------------------------
  // External dimming gates
  // ---------------------------------------------------------------
  led_cfg_pkg::channel_set_t next_ext_gate;
  logic                      pin_live;

  // Deselected outputs stay fully on from the dimming side;
  // a selected output stays dark while the pin is disabled
  always_comb begin
    pin_live = PWM_PIN_ENABLE_I;
    next_ext_gate.red_output       = !next_ext_sel.red_output       || (pin_live && PWM_PIN_I);
    next_ext_gate.green_output     = !next_ext_sel.green_output     || (pin_live && PWM_PIN_I);
    next_ext_gate.blue_output      = !next_ext_sel.blue_output      || (pin_live && PWM_PIN_I);
    next_ext_gate.primary_string   = !next_ext_sel.primary_string   || (pin_live && PWM_PIN_I);
    next_ext_gate.secondary_string = !next_ext_sel.secondary_string || (pin_live && PWM_PIN_I);
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      EXT_GATE_O <= '1;
    end else begin
      EXT_GATE_O <= next_ext_gate;
    end
  end

  // ---------------------------------------------------------------
  // Safety status
  // ---------------------------------------------------------------
  logic                      next_safety_flag;

  always_comb begin
    next_safety_flag = SAFETY_TRIPPED_I;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SAFETY_FLAG_O <= 1'b0;
    end else begin
      SAFETY_FLAG_O <= next_safety_flag;
    end
  end

endmodule : led_boost_pwm_config_regs

// [include/led_cfg_pkg.sv]
// Constants and types for the converter and external dimming configuration registers
package led_cfg_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam logic [7:0]  CONV_SETTING_ADR = 8'h0D;
  localparam logic [7:0]  DIM_SAFETY_ADR   = 8'h2B;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CONV_SETTING_RST = 8'h08;
  localparam logic [7:0]  DIM_SAFETY_RST   = 8'h00;
  localparam logic [7:0]  UNMAPPED_RDATA   = 8'h00;

  // ---------------------------------------------------------------
  // Converter code range, one volt per code step
  // ---------------------------------------------------------------
  localparam logic [7:0]  CONV_CODE_MIN    = 8'h08;
  localparam logic [7:0]  CONV_CODE_MAX    = 8'h14;

  // ---------------------------------------------------------------
  // Field positions of the dimming and safety register
  // ---------------------------------------------------------------
  localparam int          SAFETY_RED_POS   = 7;
  localparam int          SAFETY_GREEN_POS = 6;
  localparam int          SAFETY_BLUE_POS  = 5;
  localparam int          EXT_RED_POS      = 4;
  localparam int          EXT_GREEN_POS    = 3;
  localparam int          EXT_BLUE_POS     = 2;
  localparam int          EXT_PRIMARY_POS  = 1;
  localparam int          EXT_SECOND_POS   = 0;

  // Field layout, msb first, matching the positions above
  typedef struct packed {
    logic red_safety_on;
    logic green_safety_on;
    logic blue_safety_on;
    logic red_pin_dimming_on;
    logic green_pin_dimming_on;
    logic blue_pin_dimming_on;
    logic primary_string_pin_dimming_on;
    logic secondary_string_pin_dimming_on;
  } dim_safety_t;

  // Per output gated controls handed to the drivers
  typedef struct packed {
    logic red_output;
    logic green_output;
    logic blue_output;
    logic primary_string;
    logic secondary_string;
  } channel_set_t;

  // Register port request from the serial interface
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : led_cfg_pkg

// [verification/led_cfg_properties.sv]
// Checker of the configuration register outputs
`timescale 1ns/1ns
module led_cfg_props (
  input wire logic                      CLK_I,            // Clock
  input wire logic                      RESET_N_I,        // Reset
  input wire led_cfg_pkg::reg_req_t     REQ_I,            // Request
  input wire logic                      PWM_PIN_I,        // Pin
  input wire logic                      PWM_PIN_ENABLE_I, // Pin enable
  input wire logic                      BOOST_ENABLE_I,   // Run enable
  input wire logic                      SAFETY_TRIPPED_I, // Trip
  input wire logic [7:0]                RDATA_O,          // Data
  input wire logic                      RVALID_O,         // Valid
  input wire logic [7:0]                CONV_CODE_O,      // Code
  input wire logic                      CONV_CODE_OK_O,   // In range
  input wire logic                      CONV_RUN_O,       // Run
  input wire led_cfg_pkg::channel_set_t SAFETY_EN_O,      // Safety
  input wire led_cfg_pkg::channel_set_t EXT_SEL_O,        // Select
  input wire led_cfg_pkg::channel_set_t EXT_GATE_O,       // Gate
  input wire logic                      SAFETY_FLAG_O     // Status
);
  wire on_conv = REQ_I.addr == led_cfg_pkg::CONV_SETTING_ADR;
  wire on_dim  = REQ_I.addr == led_cfg_pkg::DIM_SAFETY_ADR;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_conv_read: assert property (REQ_I.rd && on_conv |=> RVALID_O && RDATA_O == $past(CONV_CODE_O))
    else $error("converter read wrong");
  a_dim_read: assert property (REQ_I.rd && on_dim |=> RDATA_O == {$past(SAFETY_EN_O[4:2]), $past(EXT_SEL_O)})
    else $error("dimming read wrong");
  a_conv_write: assert property (REQ_I.wr && on_conv |=> CONV_CODE_O == $past(REQ_I.wdata))
    else $error("code not stored");
  a_code_range: assert property (CONV_CODE_OK_O == (CONV_CODE_O >= 8'h08 && CONV_CODE_O <= 8'h14))
    else $error("range flag wrong");
  a_safety_map: assert property (REQ_I.wr && on_dim |=> SAFETY_EN_O == {$past(REQ_I.wdata[7:5]), 2'b00})
    else $error("safety enables wrong");
  a_select_map: assert property (REQ_I.wr && on_dim |=> EXT_SEL_O == $past(REQ_I.wdata[4:0]))
    else $error("selects wrong");
  a_gate_pin: assert property ($past(RESET_N_I) |-> EXT_GATE_O == (~EXT_SEL_O | {5{$past(PWM_PIN_ENABLE_I && PWM_PIN_I)}}))
    else $error("gate wrong");
  a_run_follow: assert property ($past(RESET_N_I) |-> CONV_RUN_O == $past(BOOST_ENABLE_I))
    else $error("run wrong");
  a_flag_follow: assert property ($past(RESET_N_I) |-> SAFETY_FLAG_O == $past(SAFETY_TRIPPED_I))
    else $error("status wrong");
  a_valid_pulse: assert property ($past(RESET_N_I) |-> RVALID_O == $past(REQ_I.rd))
    else $error("read valid wrong");
  c_conv_wr: cover property (REQ_I.wr && on_conv);
  c_dim_rd: cover property (REQ_I.rd && on_dim);
  c_gate_low: cover property (EXT_SEL_O != 5'h00 && EXT_GATE_O == 5'h00);
  c_pin_off: cover property (EXT_SEL_O != 5'h00 && !PWM_PIN_ENABLE_I && PWM_PIN_I);
endmodule : led_cfg_props
bind led_boost_pwm_config_regs led_cfg_props u_props (.CLK_I, .RESET_N_I, .REQ_I, .PWM_PIN_I, .PWM_PIN_ENABLE_I,
  .BOOST_ENABLE_I, .SAFETY_TRIPPED_I, .RDATA_O, .RVALID_O, .CONV_CODE_O, .CONV_CODE_OK_O, .CONV_RUN_O,
  .SAFETY_EN_O, .EXT_SEL_O, .EXT_GATE_O, .SAFETY_FLAG_O);

// [verification/led_host_model.sv]
// Host side request driver
`timescale 1ns/1ns
module led_host_model (
  input  wire logic            clk_i,    // Clock
  input  wire logic            rvalid_i, // Valid
  input  wire logic [7:0]      rdata_i,  // Data
  output led_cfg_pkg::reg_req_t req_o    // Request
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = {a, d, 2'b10};
    @(negedge clk_i);
    req_o = {~a, ~d, 2'b00};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o = {a, 8'h5A, 2'b01};
    @(negedge clk_i);
    req_o = {~a, 8'hA5, 2'b00};
    d = rvalid_i ? rdata_i : 8'hXX;
  endtask : rd
endmodule : led_host_model

// [verification/led_boost_pwm_config_regs_tb_top.sv]
// Self-checking bench of the configuration registers
`timescale 1ns/1ns
module led_boost_pwm_config_regs_tb_top;
  localparam logic [7:0] conv_a = led_cfg_pkg::CONV_SETTING_ADR;
  localparam logic [7:0] dim_a  = led_cfg_pkg::DIM_SAFETY_ADR;
  logic clk = 1'b0, rst_n = 1'b0, pin = 1'b0, pin_en = 1'b0, boost = 1'b0, trip = 1'b0;
  logic rvalid, ok, run, flag;
  logic [7:0] rdata, code, v, b;
  led_cfg_pkg::reg_req_t req;
  led_cfg_pkg::channel_set_t saf, sel, gate;
  int fail_count = 0;
  int compares = 0;
  always #2 clk = ~clk;
  led_host_model HOST (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));
  led_boost_pwm_config_regs DUT (.CLK_I(clk), .RESET_N_I(rst_n), .REQ_I(req), .PWM_PIN_I(pin),
    .PWM_PIN_ENABLE_I(pin_en), .BOOST_ENABLE_I(boost), .SAFETY_TRIPPED_I(trip), .RDATA_O(rdata),
    .RVALID_O(rvalid), .CONV_CODE_O(code), .CONV_CODE_OK_O(ok), .CONV_RUN_O(run), .SAFETY_EN_O(saf),
    .EXT_SEL_O(sel), .EXT_GATE_O(gate), .SAFETY_FLAG_O(flag));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    HOST.rd(a, d);
    chk("read", e, d);
  endtask : rchk
  task automatic conv_case(input logic [7:0] c, input logic e);
    HOST.wr(conv_a, c);
    chk("code_ok", {7'h0, e}, {7'h0, ok});
    chk("code", c, code);
    rchk(conv_a, c);
  endtask : conv_case
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #8000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("code", 8'h08, code);
    chk("code_ok", 8'h01, {7'h0, ok});
    chk("gate", 8'h1F, {3'h0, gate});
    rchk(conv_a, 8'h08);
    rchk(dim_a, 8'h00);
    rchk(8'h0C, 8'h00);
    for (int i = 8; i <= 20; i++) begin
      v = i[7:0];
      conv_case(v, 1'b1);
    end
    conv_case(8'h07, 1'b0);
    conv_case(8'h15, 1'b0);
    conv_case(8'hFF, 1'b0);
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      HOST.wr(dim_a, b);
      chk("safety", {3'h0, b[7:5], 2'h0}, {3'h0, saf});
      chk("select", {3'h0, b[4:0]}, {3'h0, sel});
      chk("gate", {3'h0, ~b[4:0]}, {3'h0, gate});
      rchk(dim_a, b);
    end
    HOST.wr(dim_a, 8'hFF);
    pin = 1'b1;
    boost = 1'b1;
    @(negedge clk);
    chk("gate", 8'h00, {3'h0, gate});
    chk("status", 8'h02, {6'h0, run, flag});
    pin_en = 1'b1;
    trip = 1'b1;
    @(negedge clk);
    chk("gate", 8'h1F, {3'h0, gate});
    chk("status", 8'h03, {6'h0, run, flag});
    pin = 1'b0;
    boost = 1'b0;
    @(negedge clk);
    chk("gate", 8'h00, {3'h0, gate});
    chk("status", 8'h01, {6'h0, run, flag});
    rst_n = 1'b0;
    boost = 1'b1;
    @(negedge clk);
    chk("code", 8'h08, code);
    chk("safety", 8'h00, {3'h0, saf});
    chk("select", 8'h00, {3'h0, sel});
    chk("gate", 8'h1F, {3'h0, gate});
    chk("status", 8'h00, {6'h0, run, flag});
    rst_n = 1'b1;
    boost = 1'b0;
    trip = 1'b0;
    rchk(conv_a, 8'h08);
    rchk(dim_a, 8'h00);
    print_verdict();
  end
endmodule : led_boost_pwm_config_regs_tb_top
